// [hw/asm_crc16.sv]
// Registered 16-bit checksum of one register word, polynomial selectable
`timescale 1ns/1ps
module asm_crc16 (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] data_i,
  input  wire logic        ansi_i,
  output logic      [15:0] crc_o
);
  import asm_pkg::*;

  // Bitwise MSB-first checksum over one word
  function automatic logic [15:0] crc_word(input logic [15:0] d, input logic [15:0] poly);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction

  // Result follows the word one edge later
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      crc_o <= 16'h0000;
    end
    else
    begin
      crc_o <= crc_word(data_i, ansi_i ? CRC_POLY_ANSI : CRC_POLY_CCITT);
    end
  end

endmodule

// [hw/asm_flags.sv]
// Bank of sticky event flags where a set beats a same-cycle clear
`timescale 1ns/1ps
module asm_flags #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  // Hold until cleared, new events win
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flags_o <= '0;
    end
    else
    begin
      flags_o <= (flags_o & ~clr_i) | set_i;
    end
  end

endmodule

// [hw/asm_pkg.sv]
// Constants and types for the converter status and mode register pair
package asm_pkg;

  // APB geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0]        STATUS_IDX  = 6'h01;
  localparam logic [5:0]        MODE_IDX    = 6'h02;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] MODE_ADDR   = {MODE_IDX, 2'b00};

  // Status word fields
  localparam int LOCK_BIT        = 15;
  localparam int RESYNC_SEEN_BIT = 14;
  localparam int MAP_CHANGED_BIT = 13;
  localparam int RX_CRC_ERR_BIT  = 12;
  localparam int ST_CRC_TYPE_BIT = 11;
  localparam int RESET_SEEN_BIT  = 10;
  localparam int ST_WSIZE_LSB    = 8;
  localparam int NUM_CHAN        = 6;
  localparam int CHAN0_NEW_SAMPLE_BIT = 0;
  localparam int CHAN5_NEW_SAMPLE_BIT = 5;

  // Mode word fields
  localparam int MAP_CRC_EN_BIT  = 13;
  localparam int RX_CRC_EN_BIT   = 12;
  localparam int CRC_TYPE_BIT    = 11;
  localparam int RESET_ACK_BIT   = 10;
  localparam int WSIZE_LSB       = 8;
  localparam int TIMEOUT_EN_BIT  = 4;
  localparam int DRDY_CFG_LSB    = 0;
  localparam int DRDY_CFG_W      = 4;

  // Values after reset and writable-bit mask
  localparam logic [REG_W-1:0] MODE_RESET   = 16'h0510;
  localparam logic [REG_W-1:0] STATUS_RESET = 16'h0500;
  localparam logic [REG_W-1:0] MODE_WMASK   = 16'h3F1F;

  // Checksum polynomials and seed
  localparam logic [15:0] CRC_POLY_CCITT = 16'h1021;
  localparam logic [15:0] CRC_POLY_ANSI  = 16'h8005;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;

  // Output word length selections
  typedef enum logic [1:0] {
    WS_16      = 2'b00,
    WS_24      = 2'b01,
    WS_32_ZPAD = 2'b10,
    WS_32_SEXT = 2'b11
  } asm_wsize_e;

  // APB slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_HOLD = 3'b100
  } asm_state_e;

endpackage

// [hw/asm_regs.sv]
// Status and mode register pair of the six-channel converter, APB slave
//
// Contract
// RL1 - Status bit 15 shows interface lock, 0 after reset.
// RL2 - Status bit 14 sets on every resynchronization, 0 after reset.
// RL3 - Status bit 13 shows register-map checksum changed, 0 after reset.
// RL4 - Status bit 12 sets on an input frame checksum error.
// RL5 - Status bit 11 shows polynomial: 0 CCITT default, 1 ANSI.
// RL6 - Status bit 10 is 1 after any reset until cleared.
// RL7 - Status bits 9:8 show word length, 24 bits by default.
// RL8 - Status bits 7:6 and mode bits 15:14 always read 00.
// RL9 - Status bits 5..0 flag new data for channels 5..0, reset 0.
// RL10 - Mode bit 13 enables register-map checksum, off after reset.
// RL11 - Mode bit 12 enables input frame checksum checking, off by default.
// RL12 - Mode bit 11 picks polynomial for both checksums, CCITT default.
// RL13 - Host writes 0 to mode bit 10; device clears reset flag.
// RL14 - Mode bits 9:8 select output word length, 24 bits default.
// RL15 - Host writes 000 to reserved mode bits 7:5.
// RL16 - Mode bit 4 enables serial timeout, on after reset.
// RL17 - Mode word at index 02h, value 0510h after reset.
// RL18 - Status word at index 01h, value 0500h after reset.
// RL19 - Writes to the status word change nothing.
// RL20 - Status polynomial and word length mirror the mode fields.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module asm_regs (
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  // APB slave
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [asm_pkg::ADDR_W-1:0]     paddr_i,
  input  wire logic [asm_pkg::DATA_W-1:0]     pwdata_i,
  input  wire logic [3:0]                     pstrb_i,
  output logic      [asm_pkg::DATA_W-1:0]     prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  // Core events and levels
  input  wire logic                           lock_i,
  input  wire logic                           resync_i,
  input  wire logic                           rx_crc_bad_i,
  input  wire logic [asm_pkg::NUM_CHAN-1:0]   chan_new_sample_i,
  input  wire logic [asm_pkg::NUM_CHAN-1:0]   chan_data_read_i,
  // Mode outputs
  output logic                                map_crc_en_o,
  output logic                                rx_crc_en_o,
  output logic                                crc_ansi_o,
  output asm_pkg::asm_wsize_e                 word_size_sel_o,
  output logic                                timeout_en_o,
  output logic      [asm_pkg::DRDY_CFG_W-1:0] drdy_cfg_o,
  output logic      [15:0]                    map_crc_o
);
  import asm_pkg::*;

  asm_state_e              state;
  logic [REG_W-1:0]        mode;
  logic [REG_W-1:0]        next_mode;
  logic [REG_W-1:0]        status_word;
  logic [REG_W-1:0]        rd_snap;
  logic                    lock_q;
  logic [2:0]              ev_set;
  logic [2:0]              ev_clr;
  logic [2:0]              ev_flags;
  logic [NUM_CHAN-1:0]     chan_clr;
  logic [NUM_CHAN-1:0]     chan_flags;
  logic [15:0]             crc_now;
  logic [15:0]             crc_ref;
  logic                    crc_ref_valid;
  logic                    map_change;
  logic                    xfer_done;
  logic                    wr_mode;
  logic                    rd_status;
  logic                    rx_err_gated;

  // Word-aligned address decode to a register index
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // Known register at this address
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) &&
           ((reg_index(a) == STATUS_IDX) || (reg_index(a) == MODE_IDX));
  endfunction

  // Byte-lane merge for the 16-bit register
  function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old,
                                                   input logic [REG_W-1:0] wd,
                                                   input logic [1:0]       strb);
    logic [REG_W-1:0] r;
    r = old;
    if (strb[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Completion edge and what it does
  assign xfer_done = (state == ST_RESP) && psel_i && penable_i;
  assign wr_mode   = xfer_done && pwrite_i && is_mapped(paddr_i) &&
                     (reg_index(paddr_i) == MODE_IDX);
  assign rd_status = xfer_done && !pwrite_i && is_mapped(paddr_i) &&
                     (reg_index(paddr_i) == STATUS_IDX);

  // APB handshake: ready in the second access cycle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (psel_i && penable_i)
          begin
            state <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          state <= ST_HOLD;
        end
        ST_HOLD:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Ready, error and read data registered
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      rd_snap   <= '0;
    end
    else if ((state == ST_IDLE) && psel_i && penable_i)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= !is_mapped(paddr_i);
      if (!pwrite_i && is_mapped(paddr_i))
      begin
        if (reg_index(paddr_i) == STATUS_IDX)
        begin
          prdata_o <= {16'h0000, status_word};
          rd_snap  <= status_word;
        end
        else
        begin
          prdata_o <= {16'h0000, mode};
          rd_snap  <= '0;
        end
      end
      else
      begin
        prdata_o <= '0;
        rd_snap  <= '0;
      end
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Mode word update from a host write; status writes fall through
  always_comb
  begin
    next_mode = mode;
    if (wr_mode)                                                   // [RL19]
    begin
      next_mode = lane_merge(mode, pwdata_i[REG_W-1:0], pstrb_i[1:0]) & MODE_WMASK; // [RL8]
      // Acknowledge only clears; writing 1 cannot fake a reset
      next_mode[RESET_ACK_BIT] = mode[RESET_ACK_BIT] &
                                 (next_mode[RESET_ACK_BIT] | !pstrb_i[1]); // [RL13]
    end
  end

  // Mode register, reset pattern 0510h
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode <= MODE_RESET;                                          // [RL17]
    end
    else
    begin
      mode <= next_mode;                                           // [RL10] [RL11] [RL16]
    end
  end

  // Mode fields driven out to the converter core
  // Taken from next_mode so the pins move at the same edge as the register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      map_crc_en_o    <= MODE_RESET[MAP_CRC_EN_BIT];
      rx_crc_en_o     <= MODE_RESET[RX_CRC_EN_BIT];
      crc_ansi_o      <= MODE_RESET[CRC_TYPE_BIT];
      word_size_sel_o <= asm_wsize_e'(MODE_RESET[WSIZE_LSB +: 2]);
      timeout_en_o    <= MODE_RESET[TIMEOUT_EN_BIT];
      drdy_cfg_o      <= MODE_RESET[DRDY_CFG_LSB +: DRDY_CFG_W];
    end
    else
    begin
      map_crc_en_o    <= next_mode[MAP_CRC_EN_BIT];                // [RL10]
      rx_crc_en_o     <= next_mode[RX_CRC_EN_BIT];                 // [RL11]
      crc_ansi_o      <= next_mode[CRC_TYPE_BIT];                  // [RL12]
      word_size_sel_o <= asm_wsize_e'(next_mode[WSIZE_LSB +: 2]);  // [RL14]
      timeout_en_o    <= next_mode[TIMEOUT_EN_BIT];                // [RL16]
      drdy_cfg_o      <= next_mode[DRDY_CFG_LSB +: DRDY_CFG_W];
    end
  end

  // Checksum of the register map, aligned with the mode register
  asm_crc16 u_map_crc (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .data_i (next_mode),
    .ansi_i (next_mode[CRC_TYPE_BIT]),                             // [RL12]
    .crc_o  (crc_now)
  );

  // Reference checksum, refreshed every edge while checking is switched on
  // Reference trails by one edge, so a change flags once and never repeats
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      crc_ref       <= 16'h0000;
      crc_ref_valid <= 1'b0;
    end
    else if (!mode[MAP_CRC_EN_BIT])
    begin
      crc_ref_valid <= 1'b0;
    end
    else
    begin
      crc_ref       <= crc_now;
      crc_ref_valid <= 1'b1;
    end
  end

  // Change seen only while the map checksum is enabled
  assign map_change = mode[MAP_CRC_EN_BIT] && crc_ref_valid &&
                      (crc_now != crc_ref);                        // [RL3] [RL10]

  // Published checksum value
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      map_crc_o <= 16'h0000;
    end
    else
    begin
      map_crc_o <= crc_now;
    end
  end

  // Lock level sampled into the status word
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_i;                                            // [RL1]
    end
  end

  // Frame checksum errors only count while checking is on
  assign rx_err_gated = rx_crc_bad_i && mode[RX_CRC_EN_BIT];      // [RL4] [RL11]

  // Sticky event sources; clear only bits the host actually saw
  // A flag raised after the read capture survives that read's clear
  assign ev_set = {resync_i,                                       // [RL2]
                   map_change,                                     // [RL3]
                   rx_err_gated};                                  // [RL4]
  assign ev_clr = rd_status ? {rd_snap[RESYNC_SEEN_BIT],
                               rd_snap[MAP_CHANGED_BIT],
                               rd_snap[RX_CRC_ERR_BIT]} : 3'b000;

  asm_flags #(
    .W (3)
  ) u_event_flags (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .set_i   (ev_set),
    .clr_i   (ev_clr),
    .flags_o (ev_flags)
  );

  // Per-channel new-sample flags, cleared by the channel data read
  assign chan_clr = chan_data_read_i;

  asm_flags #(
    .W (NUM_CHAN)
  ) u_chan_flags (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .set_i   (chan_new_sample_i),                                  // [RL9]
    .clr_i   (chan_clr),
    .flags_o (chan_flags)
  );

  // Status word assembly
  always_comb
  begin
    status_word                  = 16'h0000;                      // [RL8]
    status_word[LOCK_BIT]        = lock_q;                        // [RL1]
    status_word[RESYNC_SEEN_BIT] = ev_flags[2];                   // [RL2]
    status_word[MAP_CHANGED_BIT] = ev_flags[1];                   // [RL3]
    status_word[RX_CRC_ERR_BIT]  = ev_flags[0];                   // [RL4]
    status_word[ST_CRC_TYPE_BIT] = mode[CRC_TYPE_BIT];            // [RL5] [RL20]
    status_word[RESET_SEEN_BIT]  = mode[RESET_ACK_BIT];           // [RL6] [RL13]
    status_word[ST_WSIZE_LSB +: 2] = mode[WSIZE_LSB +: 2];        // [RL7] [RL20]
    status_word[CHAN0_NEW_SAMPLE_BIT +: NUM_CHAN] = chan_flags;   // [RL9] [RL18]
  end

endmodule

// [tb/asm_host.sv]
// APB master standing in for the host controller
`timescale 1ns/1ps
module asm_host (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o
);
  // Idle bus at time zero, full words only
  initial
  begin
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwrite_o  <= 1'b0;
    paddr_o   <= 8'h00;
    pwdata_o  <= 32'h0;
    pstrb_o   <= 4'hF;
  end
  // Setup, access, hold until ready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o  <= ~d; // Released data shows no stale word
  endtask
endmodule

// [tb/asm_regs_chk.sv]
// Concurrent checks on the ports of the status and mode register pair
`timescale 1ns/1ps
module asm_regs_chk (
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [asm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [asm_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0]                 pstrb_i,
  input wire logic [asm_pkg::DATA_W-1:0] prdata_o,
  input wire logic                       pready_o,
  input wire logic                       pslverr_o,
  input wire logic                       lock_i,
  input wire logic                       map_crc_en_o,
  input wire logic                       rx_crc_en_o,
  input wire logic                       crc_ansi_o,
  input wire asm_pkg::asm_wsize_e        word_size_sel_o,
  input wire logic                       timeout_en_o
);
  import asm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic        acc;
  logic        rd_st;
  logic [31:0] wd_q;
  // Completing transfer and status read
  assign acc   = psel_i && penable_i && pready_o;
  assign rd_st = acc && !pwrite_i && paddr_i == STATUS_ADDR;
  // Write data one edge late
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      wd_q <= 32'h0;
    else
      wd_q <= pwdata_i;
  wait_state_a: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (
    acc && paddr_i != STATUS_ADDR && paddr_i != MODE_ADDR |-> pslverr_o)
    else $error("no error on unmapped address");
  reserved_zero_a: assert property (
    acc && !pwrite_i |->
    (paddr_i == STATUS_ADDR ? prdata_o[7:6] : prdata_o[15:14]) == 2'b00)
    else $error("reserved bits read nonzero");
  mode_mirror_a: assert property (
    rd_st |-> prdata_o[11] == crc_ansi_o && prdata_o[9:8] == word_size_sel_o)
    else $error("status does not mirror mode");
  lock_view_a: assert property (
    psel_i && penable_i && !pready_o && !pwrite_i
    && paddr_i == STATUS_ADDR && $stable(lock_i) |=> prdata_o[15] == $past(lock_i))
    else $error("lock bit differs from lock input");
  mode_write_a: assert property (
    acc && pwrite_i && paddr_i == MODE_ADDR && pstrb_i == 4'hF |=>
    {map_crc_en_o, rx_crc_en_o, crc_ansi_o, word_size_sel_o, timeout_en_o}
    == {wd_q[13:11], wd_q[9:8], wd_q[4]})
    else $error("mode outputs differ from written word");
  status_ro_a: assert property (
    acc && pwrite_i && paddr_i == STATUS_ADDR |=>
    $stable({map_crc_en_o, rx_crc_en_o, crc_ansi_o, word_size_sel_o, timeout_en_o}))
    else $error("status write changed mode");
endmodule
bind asm_regs asm_regs_chk chk_u (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .lock_i, .map_crc_en_o, .rx_crc_en_o,
  .crc_ansi_o, .word_size_sel_o, .timeout_en_o);

// [tb/tb_asm_regs.sv]
// Self-checking bench for the converter status and mode register pair
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_asm_regs;
  import asm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        lock_i = 1'b0;
  logic        resync_i = 1'b0;
  logic        rx_crc_bad_i = 1'b0;
  logic [5:0]  chan_new_sample_i = 6'h00;
  logic [5:0]  chan_data_read_i = 6'h00;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0]  pstrb_i;
  logic [33:0] e;
  logic [33:0] expq[$];
  logic [15:0] stx, m;
  logic [5:0]  r;
  logic        map_crc_en_o, rx_crc_en_o, crc_ansi_o, timeout_en_o;
  logic [1:0]  word_size_sel_o;
  logic [3:0]  drdy_cfg_o;
  logic [15:0] map_crc_o;
  logic [9:0]  pins, pexp;
  int          fail_count = 0, compares = 0, tick = 0;

  always #50 clk_i = ~clk_i;

  asm_host host_u (.clk_i(clk_i), .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));
  asm_regs dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .lock_i(lock_i),
    .resync_i(resync_i), .rx_crc_bad_i(rx_crc_bad_i), .chan_new_sample_i(chan_new_sample_i),
    .chan_data_read_i(chan_data_read_i), .map_crc_en_o(map_crc_en_o),
    .rx_crc_en_o(rx_crc_en_o), .crc_ansi_o(crc_ansi_o), .word_size_sel_o(word_size_sel_o),
    .timeout_en_o(timeout_en_o), .drdy_cfg_o(drdy_cfg_o), .map_crc_o(map_crc_o));

  // Expected map checksum: seed, MSB first, polynomial from the word itself
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    logic [15:0] p;
    c = CRC_INIT;
    p = d[CRC_TYPE_BIT] ? CRC_POLY_ANSI : CRC_POLY_CCITT;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ({16{c[15] ^ d[i]}} & p);
    return c;
  endfunction

  // Verdict and end of run
  task automatic test_done();
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bus tasks note the expected answer before driving
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic err);
    expq.push_back({1'b0, err, 32'h0});
    host_u.xfer(1'b1, a, {16'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic err);
    expq.push_back({1'b1, err, 16'h0, d});
    host_u.xfer(1'b0, a, 32'h0);
  endtask
  // Status read; event flags that read 1 are gone afterwards
  task automatic rds();
    rd(STATUS_ADDR, stx, 1'b0);
    stx[14:12] = 3'b000;
  endtask

  // Compare each completed transfer with the oldest note
  always @(posedge clk_i)
    if (psel_i && penable_i && pready_o === 1'b1)
    begin
      e = expq.pop_front();
      `CHK("pslverr", e[32], pslverr_o)
      if (e[33])
        `CHK("prdata", e[31:0], prdata_o)
      // Mode pins and checksum must match the mode word read back
      if (e[33] && paddr_i == MODE_ADDR)
      begin
        pins = {map_crc_en_o, rx_crc_en_o, crc_ansi_o, word_size_sel_o,
                timeout_en_o, drdy_cfg_o};
        pexp = {e[13:11], e[9:8], e[4:0]};
        `CHK("mode_pins", pexp, pins)
        `CHK("map_crc", crc16(e[15:0]), map_crc_o)
      end
    end

  // Watchdog
  always @(posedge clk_i)
  begin
    tick++;
    if (tick == 3000)
    begin
      fail_count++;
      test_done();
    end
  end

  initial
  begin
    void'($urandom(32'h4ce793e9));
    stx = STATUS_RESET;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rds();
    rd(MODE_ADDR, MODE_RESET, 1'b0);
    rd(8'h0C, 16'h0, 1'b1);
    wr(8'h05, 16'h0, 1'b1);
    wr(STATUS_ADDR, 16'hFFFF, 1'b0);
    rds();
    // Lock, resync, new samples, ignored checksum error
    r = 6'($urandom_range(63, 1));
    lock_i <= 1'b1;
    resync_i <= 1'b1;
    rx_crc_bad_i <= 1'b1;
    chan_new_sample_i <= r;
    @(posedge clk_i);
    resync_i <= 1'b0;
    rx_crc_bad_i <= 1'b0;
    chan_new_sample_i <= 6'h00;
    stx[15:14] = 2'b11;
    stx[5:0] = r;
    rds();
    rds();
    chan_data_read_i <= r;
    @(posedge clk_i);
    chan_data_read_i <= 6'h00;
    stx[5:0] = 6'h00;
    rds();
    // Input checksum errors counted once enabled
    wr(MODE_ADDR, 16'h1510, 1'b0);
    rx_crc_bad_i <= 1'b1;
    @(posedge clk_i);
    rx_crc_bad_i <= 1'b0;
    stx[12] = 1'b1;
    rds();
    // Every word length and polynomial, reserved bits written 000
    for (int i = 0; i < 8; i++)
    begin
      m = {3'b000, 1'($urandom), i[0], 1'b1, i[2:1], 3'b000, 5'($urandom)};
      wr(MODE_ADDR, m, 1'b0);
      rd(MODE_ADDR, m, 1'b0);
      stx[11:8] = {i[0], 1'b1, i[2:1]};
      rds();
    end
    // Map checksum enable, then a change
    wr(MODE_ADDR, 16'h2510, 1'b0);
    stx[11:8] = 4'h5;
    rds();
    wr(MODE_ADDR, 16'h2D10, 1'b0);
    repeat (2) @(posedge clk_i);
    stx[13] = 1'b1;
    stx[11:8] = 4'hD;
    rds();
    rds();
    // Reset acknowledge; writing 1 back is ignored
    wr(MODE_ADDR, 16'h0910, 1'b0);
    stx[11:8] = 4'h9;
    rds();
    wr(MODE_ADDR, 16'h0510, 1'b0);
    rd(MODE_ADDR, 16'h0110, 1'b0);
    // Reset in mid-run brings the flag back
    rstn_i <= 1'b0;
    lock_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    stx = STATUS_RESET;
    rds();
    rd(MODE_ADDR, MODE_RESET, 1'b0);
    test_done();
  end
endmodule
